// [rtl/bcw_pkg.sv]
package bcw_pkg;
  localparam int CLK_KHZ = 40_000;
  localparam int UNIT_US = 1;
  localparam int UNIT_MS = 1;
  localparam int US_CYCLES_I = (UNIT_US * CLK_KHZ + 999) / 1000;
  localparam int MS_CYCLES_I = UNIT_MS * CLK_KHZ;
  localparam int DIV_W = 16;
  localparam logic [DIV_W-1:0] US_CYCLES = DIV_W'(US_CYCLES_I);
  localparam logic [DIV_W-1:0] MS_CYCLES = DIV_W'(MS_CYCLES_I);
  localparam int ADC_BITS = 12;
  localparam int IDX_W = 4;
  localparam int PULSE_W = 10;
  localparam int SCAN_CNT_W = 5;
  localparam int SCAN_MS_W = 10;
  localparam logic [ADC_BITS-1:0] ADC_MIN_CODE = 12'h000;
  localparam logic [ADC_BITS-1:0] ADC_FULL_CODE = 12'hfff;
  localparam logic [ADC_BITS-1:0] DELTA_OFF_CODE = 12'hfff;
  localparam logic [SCAN_CNT_W-1:0] REPEAT_LAST = 5'h1f;
  localparam logic [SCAN_MS_W-1:0] SCAN_NORMAL_MS = 10'h020;
  localparam logic [SCAN_MS_W-1:0] SCAN_IDLE_MS = 10'h100;
  localparam logic [SCAN_MS_W-1:0] SCAN_DOZE_MS = 10'h200;
  localparam logic [PULSE_W-1:0] PULSE_MIN_UNITS = 10'h001;
  localparam logic [PULSE_W-1:0] PULSE_MAX_UNITS = 10'h200;

  typedef enum logic [1:0] {PWR_NORMAL, PWR_IDLE, PWR_DOZE} bcw_power_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_PULSE, ST_CONVERT, ST_DECIDE} bcw_phase_t;

  typedef struct packed {
    logic scale_ms;
    logic [PULSE_W-1:0] count;
  } bcw_pulse_time_t;

  localparam bcw_pulse_time_t PULSE_TIME_DEFAULT = '{scale_ms: 1'b1, count: 10'h001};

  typedef struct packed {
    logic wire_test_disable;
    logic wire_fault_shutdown_enable;
    bcw_pulse_time_t wire_test_pulse_time;
    logic [ADC_BITS-1:0] cell_delta_limit;
  } bcw_cfg_t;

  typedef struct packed {
    logic wire_fault;
    logic cell_delta_fault;
    logic test_active;
    logic [IDX_W-1:0] test_input_index;
  } bcw_status_t;

  typedef struct packed {
    logic power_fet_off;
    logic balance_off;
    logic pack_shutdown_output;
  } bcw_action_t;

  typedef struct packed {
    bcw_phase_t phase;
    logic [IDX_W-1:0] idx;
    logic [PULSE_W-1:0] units;
    logic restart;
    logic cut;
    logic pass_fail;
    logic wire_fault;
    logic cell_delta_fault;
    logic armed;
    logic pending;
    logic [SCAN_CNT_W-1:0] scan_count;
    logic [SCAN_MS_W-1:0] scan_ms;
    logic adc_req;
  } bcw_state_t;

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } bcw_div_t;
endpackage

// [rtl/bcw_tick_div.sv]
`timescale 1ns/1ps
module bcw_tick_div
  import bcw_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  input wire logic [DIV_W-1:0] period,
  output logic tick
);
  bcw_div_t st;
  bcw_div_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clear) begin
      next_st.count = '0;
    end else if (st.count + DIV_W'(1) >= period) begin
      // a zero period behaves like one cycle
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + DIV_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule // bcw_tick_div

// [rtl/bcw_wire_test.sv]
`timescale 1ns/1ps
module bcw_wire_test
  import bcw_pkg::*;
#(
  parameter int CELLS = 8,
  parameter logic [DIV_W-1:0] MS_CYCLES_P = MS_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire bcw_cfg_t cfg,
  input wire bcw_power_t power_state,
  input wire logic [CELLS-1:0][ADC_BITS-1:0] cell_volts,
  input wire logic adc_valid,
  input wire logic [CELLS:0] trip,
  output logic adc_req,
  output logic [CELLS:0] test_current_en,
  output bcw_status_t status,
  output bcw_action_t action
);
  bcw_state_t st;
  bcw_state_t next_st;
  logic ms_tick;
  logic unit_tick;
  logic scan_due;
  logic fault_now;
  logic keep;
  logic bad_code;
  logic [SCAN_MS_W-1:0] interval;
  logic [PULSE_W-1:0] target;
  logic keep_d;

  function automatic logic delta_exceeds(input logic [CELLS-1:0][ADC_BITS-1:0] v,
                                         input logic [ADC_BITS-1:0] limit);
    logic [ADC_BITS-1:0] hi;
    logic [ADC_BITS-1:0] lo;
    hi = v[0];
    lo = v[0];
    for (int i = 1; i < CELLS; i++) begin
      if (v[i] > hi) hi = v[i];
      if (v[i] < lo) lo = v[i];
    end
    // the off code masks the fault even if the spread could exceed it
    return (limit != DELTA_OFF_CODE) && ((hi - lo) > limit);
  endfunction

  function automatic logic range_bad(input logic [CELLS-1:0][ADC_BITS-1:0] v);
    logic bad;
    bad = 1'b0;
    for (int i = 0; i < CELLS; i++) begin
      if (v[i] == ADC_MIN_CODE || v[i] == ADC_FULL_CODE) bad = 1'b1;
    end
    return bad;
  endfunction

  bcw_tick_div u_ms_div (
    .clk(clk),
    .reset(reset),
    .clear(1'b0),
    .period(MS_CYCLES_P),
    .tick(ms_tick)
  );

  // restarting per input keeps every pulse at least its programmed length, capped at PULSE_MAX_UNITS
  bcw_tick_div u_pulse_div (
    .clk(clk),
    .reset(reset),
    .clear(st.phase != ST_PULSE || st.restart),
    .period(cfg.wire_test_pulse_time.scale_ms ? MS_CYCLES_P : US_CYCLES),
    .tick(unit_tick)
  );

  always_comb begin
    unique case (power_state)
      PWR_IDLE: interval = SCAN_IDLE_MS;
      PWR_DOZE: interval = SCAN_DOZE_MS;
      default: interval = SCAN_NORMAL_MS;
    endcase
    if (cfg.wire_test_pulse_time.count < PULSE_MIN_UNITS) begin
      target = PULSE_MIN_UNITS;
    end else if (cfg.wire_test_pulse_time.count > PULSE_MAX_UNITS) begin
      target = PULSE_MAX_UNITS;
    end else begin
      target = cfg.wire_test_pulse_time.count;
    end
  end

  always_comb begin
    next_st = st;
    next_st.adc_req = 1'b0;
    next_st.restart = 1'b0;
    scan_due = 1'b0;
    fault_now = delta_exceeds(cell_volts, cfg.cell_delta_limit);
    keep = fault_now || st.wire_fault;
    bad_code = range_bad(cell_volts);
    // scan pacing ignores the wire fault entirely
    if (ms_tick) begin
      if (st.scan_ms + SCAN_MS_W'(1) >= interval) begin
        next_st.scan_ms = '0;
        scan_due = 1'b1;
      end else begin
        next_st.scan_ms = st.scan_ms + SCAN_MS_W'(1);
      end
    end
    unique case (st.phase)
      ST_IDLE: begin
        // a scan tick during a test pass is dropped, the pass owns the adc
        if (scan_due) begin
          next_st.phase = ST_SCAN;
          next_st.adc_req = 1'b1;
        end
      end
      ST_SCAN: begin
        if (adc_valid) begin
          next_st.cell_delta_fault = fault_now;
          next_st.phase = ST_IDLE;
          if (!keep || cfg.wire_test_disable) begin
            next_st.armed = 1'b0;
            next_st.pending = 1'b0;
            next_st.scan_count = '0;
          end else if (!st.armed) begin
            next_st.armed = 1'b1;
            next_st.pending = 1'b1;
            next_st.scan_count = '0;
          end else if (st.pending || st.scan_count == REPEAT_LAST) begin
            next_st.pending = 1'b0;
            next_st.scan_count = '0;
            next_st.phase = ST_PULSE;
            next_st.idx = '0;
            next_st.units = '0;
            next_st.cut = 1'b0;
            next_st.pass_fail = 1'b0;
            next_st.restart = 1'b1;
          end else begin
            next_st.scan_count = st.scan_count + SCAN_CNT_W'(1);
          end
        end
      end
      ST_PULSE: begin
        if (trip[st.idx]) begin
          next_st.cut = 1'b1;
        end
        if (|trip) begin
          next_st.pass_fail = 1'b1;
          next_st.wire_fault = 1'b1;
        end
        if (unit_tick) begin
          if (st.units + PULSE_W'(1) >= target) begin
            if (st.idx == IDX_W'(CELLS)) begin
              next_st.phase = ST_CONVERT;
              next_st.adc_req = 1'b1;
            end else begin
              next_st.idx = st.idx + IDX_W'(1);
              next_st.units = '0;
              next_st.cut = 1'b0;
              next_st.restart = 1'b1;
            end
          end else begin
            next_st.units = st.units + PULSE_W'(1);
          end
        end
      end
      ST_CONVERT: begin
        if (adc_valid) begin
          if (bad_code) begin
            next_st.pass_fail = 1'b1;
            next_st.wire_fault = 1'b1;
          end
          next_st.phase = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (!st.pass_fail) begin
          next_st.wire_fault = 1'b0;
        end
        next_st.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{phase: ST_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  // comparator output gates its own current without waiting for a clock
  for (genvar g = 0; g <= CELLS; g++) begin : g_src
    assign test_current_en[g] = (st.phase == ST_PULSE) && (st.idx == IDX_W'(g)) &&
                                !st.cut && !trip[g];
  end

  assign adc_req = st.adc_req;
  assign status.wire_fault = st.wire_fault;
  assign status.cell_delta_fault = st.cell_delta_fault;
  assign status.test_active = (st.phase == ST_PULSE) || (st.phase == ST_CONVERT) || (st.phase == ST_DECIDE);
  assign status.test_input_index = st.idx;
  assign action.power_fet_off = st.wire_fault;
  assign action.balance_off = st.wire_fault;
  assign action.pack_shutdown_output = st.wire_fault && cfg.wire_fault_shutdown_enable;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  disabled_no_start_a: assert property (
    (st.phase == ST_SCAN && next_st.phase == ST_PULSE) |-> !cfg.wire_test_disable)
    else $error("wire test started while disabled");
  one_source_a: assert property ($onehot0(test_current_en))
    else $error("more than one test current source on");
  trip_cut_a: assert property (
    (st.phase == ST_PULSE && trip[st.idx] && !unit_tick) |=> (test_current_en == '0))
    else $error("test current stays on after a trip");
  trip_flag_a: assert property (
    (st.phase == ST_PULSE && |trip) |=> (status.wire_fault && action.balance_off) [*2])
    else $error("trip did not set wire fault and stop balancing");
  range_flag_a: assert property (
    (st.phase == ST_CONVERT && adc_valid && bad_code) |=> ##1 (st.phase == ST_IDLE && status.wire_fault))
    else $error("bad conversion code did not set wire fault");
  no_shutdown_a: assert property (
    (status.wire_fault && !cfg.wire_fault_shutdown_enable) |-> (action.power_fet_off && !action.pack_shutdown_output))
    else $error("shutdown disabled case wrong");
  shutdown_on_a: assert property (
    (status.wire_fault && cfg.wire_fault_shutdown_enable) |-> (action.pack_shutdown_output && action.balance_off))
    else $error("pack shutdown not driven");
  clean_clear_a: assert property (
    (st.phase == ST_DECIDE && !st.pass_fail) |=> !status.wire_fault)
    else $error("clean pass did not clear wire fault");
  hold_fault_a: assert property (
    (status.wire_fault && st.phase != ST_DECIDE) |=> status.wire_fault)
    else $error("wire fault dropped without a clean pass");
  max_limit_a: assert property (
    (st.phase == ST_SCAN && adc_valid && cfg.cell_delta_limit == DELTA_OFF_CODE) |=> !status.cell_delta_fault)
    else $error("delta fault raised with limit at maximum");
  first_defer_a: assert property (
    (st.phase == ST_SCAN && adc_valid && !st.armed) |=> (st.phase == ST_IDLE && st.pending == keep_d))
    else $error("first fault scan did not defer the test");
  always_ff @(posedge clk) begin
    keep_d <= keep && !cfg.wire_test_disable;
  end
endmodule // bcw_wire_test

// [verif/bcw_cell_model.sv]
`timescale 1ns/1ps
module bcw_cell_model
  import bcw_pkg::*;
#(
  parameter int CELLS = 8
) (
  input wire logic clk,
  input wire logic adc_req,
  input wire logic [CELLS:0] test_current_en,
  input wire logic [CELLS-1:0][ADC_BITS-1:0] volts,
  input wire logic open_en,
  input wire logic [IDX_W-1:0] open_idx,
  input wire logic [3:0] lat,
  output logic adc_valid,
  output logic [CELLS-1:0][ADC_BITS-1:0] cell_volts,
  output logic [CELLS:0] trip
);
  logic [3:0] busy = 4'h0;
  logic [CELLS:0] open_mask;
  initial adc_valid = 1'b0;
  initial trip = '0;
  always_comb begin
    open_mask = '0;
    if (open_en) begin
      open_mask[open_idx] = 1'b1;
    end
  end
  // codes only hold while valid; the inverse elsewhere exposes a stale sample
  assign cell_volts = adc_valid ? volts : ~volts;
  always @(posedge clk) begin
    adc_valid <= (busy == 4'h1);
    busy <= adc_req ? lat : ((busy != 4'h0) ? busy - 4'h1 : 4'h0);
    // a floating input crosses its threshold once sourced; held until the next conversion
    trip <= adc_req ? '0 : (trip | (test_current_en & open_mask));
  end
endmodule // bcw_cell_model

// [verif/bcw_wire_test_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end
module bcw_wire_test_tb
  import bcw_pkg::*;
;
  localparam int MSP = 10;
  logic clk = 1'b0;
  logic reset = 1'b1;
  bcw_cfg_t cfg;
  bcw_power_t pwr;
  logic [7:0][ADC_BITS-1:0] volts, cv;
  logic adc_req, adc_valid, open_en;
  logic [8:0] en, trip;
  logic [3:0] lat;
  bcw_status_t st;
  bcw_action_t act;
  int err_total = 0, check_count = 0, cyc = 0, max_idx = 0, n, t0;
  logic seen = 1'b0;
  int ms[3] = '{32, 256, 512};

  bcw_wire_test #(.CELLS(8), .MS_CYCLES_P(DIV_W'(MSP))) u_bcw_wire_test (.clk(clk), .reset(reset), .cfg(cfg),
    .power_state(pwr), .cell_volts(cv), .adc_valid(adc_valid), .trip(trip), .adc_req(adc_req),
    .test_current_en(en), .status(st), .action(act));
  bcw_cell_model #(.CELLS(8)) u_bcw_cell_model (.clk(clk), .adc_req(adc_req), .test_current_en(en),
    .volts(volts), .open_en(open_en), .open_idx(4'h3), .lat(lat), .adc_valid(adc_valid), .cell_volts(cv),
    .trip(trip));

  always #12.5 clk = ~clk;

  task automatic stop_test();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (st.test_active === 1'b1) begin
      seen = 1'b1;
      if (int'(st.test_input_index) > max_idx) max_idx = int'(st.test_input_index);
    end
    // whole run needs about half of this
    if (cyc >= 90000) begin
      $display("[FAIL] %0t cycle limit reached", $time);
      err_total++;
      stop_test();
    end
  end

  always @(negedge clk) begin
    if (st.test_active === 1'b1) begin
      `CHK($onehot0(en), 1'b1)
      `CHK(en & trip, 9'h000)
    end
  end

  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // waits for a scan answer and lets the design take it
  task automatic wait_scan();
    int k;
    k = 0;
    do begin cyc_n(1); k++; end while (adc_valid !== 1'b1 && k < 12000);
    `CHK(k < 12000, 1'b1)
    cyc_n(1);
  endtask

  task automatic wait_req();
    int k;
    k = 0;
    do begin cyc_n(1); k++; end while (adc_req !== 1'b1 && k < 12000);
  endtask

  // toggling the disable bit restarts scheduling: arm on one scan, start on the next
  task automatic start_test();
    cfg.wire_test_disable = 1'b1;
    wait_scan();
    cfg.wire_test_disable = 1'b0;
    wait_scan();
    `CHK(st.test_active, 1'b0)
    wait_scan();
    cyc_n(1);
    `CHK(st.test_active, 1'b1)
  endtask

  task automatic finish_pass();
    int k;
    k = 0;
    while (st.test_active === 1'b1 && k < 2000) begin cyc_n(1); k++; end
    `CHK(st.test_active, 1'b0)
  endtask

  initial begin
    cfg = '{1'b0, 1'b0, PULSE_TIME_DEFAULT, 12'hfff};
    pwr = PWR_NORMAL;
    volts = {8{12'h800}};
    open_en = 1'b0;
    lat = 4'h1;
    cyc_n(10);
    reset = 1'b0;
    `CHK(act, 3'b000)
    volts[0] = 12'h100;
    volts[7] = 12'hf00;
    repeat (3) wait_scan();
    `CHK(st.cell_delta_fault, 1'b0)
    `CHK(seen, 1'b0)
    cfg.cell_delta_limit = 12'h100;
    volts[0] = 12'h800;
    volts[7] = 12'h900;
    wait_scan();
    `CHK(st.cell_delta_fault, 1'b0)
    for (int p = 0; p < 3; p++) begin
      pwr = bcw_power_t'(p);
      wait_req();
      t0 = cyc;
      wait_req();
      n = cyc - t0;
      `CHK(n >= ms[p] * MSP && n <= ms[p] * MSP + 4, 1'b1)
    end
    pwr = PWR_NORMAL;
    volts[7] = 12'h901;
    cfg.wire_test_disable = 1'b1;
    repeat (3) wait_scan();
    `CHK(st.cell_delta_fault, 1'b1)
    `CHK(seen, 1'b0)
    cfg.wire_test_pulse_time = '{1'b0, 10'h002};
    start_test();
    t0 = cyc;
    while (en[0] === 1'b1 && cyc - t0 < 300) cyc_n(1);
    `CHK(cyc - t0 >= 76 && cyc - t0 <= 86, 1'b1)
    finish_pass();
    `CHK(max_idx, 8)
    `CHK(st.wire_fault, 1'b0)
    n = 0;
    while (n < 40 && st.test_active !== 1'b1) begin wait_scan(); cyc_n(1); n++; end
    `CHK(n, 32)
    finish_pass();
    open_en = 1'b1;
    lat = 4'h6;
    start_test();
    finish_pass();
    `CHK(st.wire_fault, 1'b1)
    `CHK(act, 3'b110)
    cfg.wire_fault_shutdown_enable = 1'b1;
    cyc_n(1);
    `CHK(act, 3'b111)
    cfg.wire_fault_shutdown_enable = 1'b0;
    wait_scan();
    `CHK(st.wire_fault, 1'b1)
    open_en = 1'b0;
    lat = 4'h1;
    start_test();
    finish_pass();
    `CHK(act, 3'b000)
    for (int c = 0; c < 2; c++) begin
      volts[2] = (c == 0) ? 12'h000 : 12'hfff;
      start_test();
      finish_pass();
      `CHK(st.wire_fault, 1'b1)
      volts[2] = 12'h800;
      start_test();
      finish_pass();
      `CHK(st.wire_fault, 1'b0)
    end
    stop_test();
  end
endmodule // bcw_wire_test_tb
